// ---- logic/bpsc_pkg.sv ----
// strap loader package: register map, field layout, modes, timing.
// assumes a 200 MHz core clock and 32-bit apb data.
//
// Overview of operation
// - rising local reset latches req64_n; high means 32-bit, low 64-bit.
// - in 32-bit mode upper pci byte enables, data, parity, ack driven always.
// - first local reset rise samples m66en and pci control lines for mode.
// - stop/trdy pattern picks pci or pci-x and its frequency range.
// - width and mode latch once; reopen only when both resets reasserted.
// - during power-up reset the vme transceiver enable stays negated.
// - strap bits: sysfail enable value, hold autoclear, auto slot, geographic.
// - vme data straps latch on rising edge of power-up reset.
// - strap pair decodes to disabled, geographic, auto slot, or ga fallback.
// - vme system reset loads csr enable, hold and sysfail enable values.
// - with auto slot and autoclear, hold bit clears 1 ms after reset.
// - sysfail output held while hold bit set; else software clears it.
// - software may write the hold bit except while vme or power-up reset is asserted.
// - geographic strap sets csr enable and base bits 7..3 from inverted ga.
// - vme system reset reloads csr enable and base bits from straps.
// - auto slot requests irq2 after reset, base zero until monarch programs.
// - sysfail output is hold bit or board fail gated by sysfail enable.
// - bit-clear write disables sysfail enable; bit-set write enables it.
package bpsc_pkg;
	localparam logic [7:0] OFS_STRAP_STATUS = 8'h00;
	localparam logic [7:0] OFS_VME_CONTROL = 8'h04;
	localparam logic [7:0] OFS_SYS_CSR = 8'h08;
	localparam logic [7:0] OFS_BIT_SET = 8'h0c;
	localparam logic [7:0] OFS_BIT_CLR = 8'h10;
	localparam logic [7:0] OFS_CSR_BASE = 8'h14;
	localparam int BIT_WIDTH32 = 0;
	localparam int BIT_MODE_LO = 1;
	localparam int BIT_STRAP_LO = 4;
	localparam int BIT_SLOT_LO = 8;
	localparam int BIT_OPEN = 10;
	localparam int BIT_HOLD = 0;
	localparam int BIT_IRQ2 = 1;
	localparam int BIT_SFEN = 0;
	localparam int BIT_BOARD_FAIL = 1;
	localparam int BIT_SFOUT = 2;
	localparam int BIT_BOARD_IN = 3;
	localparam int BIT_CSR_EN = 0;
	localparam int BIT_BASE_LO = 3;
	localparam int BIT_BASE_HI = 7;
	localparam int GA_W = 5;
	localparam int AUTOCLR_TIME_MS = 1;
	localparam int CLK_FREQ_HZ = 200_000_000;
	localparam int AUTOCLR_CYC = AUTOCLR_TIME_MS * (CLK_FREQ_HZ / 1000);
	typedef enum logic [2:0] {
		MODE_PCI33, MODE_PCI66, MODE_PCIX66, MODE_PCIX100, MODE_PCIX133,
		MODE_INVALID
	} bpsc_mode_t;
	typedef enum logic [1:0] {SLOT_OFF, SLOT_GEO, SLOT_AUTO} bpsc_slot_t;
	typedef struct packed {
		logic width32;
		bpsc_mode_t mode;
	} bpsc_pci_cfg_t;
	typedef struct packed {
		logic geographic_slot_id_enable;
		logic auto_slot_id_enable;
		logic autoslot_hold_autoclear;
		logic sysfail_enable_reset_value;
	} bpsc_strap_t;
endpackage : bpsc_pkg

// ---- logic/bpsc_strap_loader.sv ----
// power-up strap loader: pci width/mode, vme strap options, sysfail control.
// assumes all pin inputs synchronous to clk; resets arrive as active-low levels.
//
// Added by the designer: the register offsets and the APB slave port.
module bpsc_strap_loader #(
	parameter int unsigned AUTOCLR_CYCLES = bpsc_pkg::AUTOCLR_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic local_bus_reset_in_n,
	input wire logic power_up_reset_in_n,
	input wire logic vme_system_reset_in_n,
	input wire logic req64_n,
	input wire logic m66en,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic trdy_n,
	input wire logic stop_n,
	input wire logic devsel_n,
	input wire logic [3:0] vme_data_strap_bits,
	input wire logic [bpsc_pkg::GA_W-1:0] ga_n,
	input wire logic board_fail_input_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic transceiver_output_enable_n,
	output logic upper_lane_drive_en,
	output bpsc_pkg::bpsc_pci_cfg_t pci_cfg,
	output logic csr_enable,
	output logic [bpsc_pkg::GA_W-1:0] csr_base_bits,
	output logic irq2_request,
	output logic sysfail_output
);
	localparam int TW = $clog2(AUTOCLR_CYCLES + 1);
	localparam logic [TW-1:0] TMR_LOAD = TW'(AUTOCLR_CYCLES);
	localparam logic [TW-1:0] TMR_ONE = TW'(1);

	logic lrst_d_reg;
	logic purst_d_reg;
	logic srst_d_reg;
	logic cfg_open_reg;
	bpsc_pkg::bpsc_pci_cfg_t pci_cfg_reg;
	bpsc_pkg::bpsc_strap_t strap_reg;
	logic csr_en_reg;
	logic [bpsc_pkg::GA_W-1:0] base_reg;
	logic hold_reg;
	logic sfen_reg;
	logic board_fail_bit_reg;
	logic irq2_reg;
	logic [TW-1:0] tmr_reg;
	logic [31:0] prdata_reg;

	// edge detection on the reset levels
	wire lrst_rise = local_bus_reset_in_n & ~lrst_d_reg;
	wire purst_rise = power_up_reset_in_n & ~purst_d_reg;
	wire vrst_active = ~vme_system_reset_in_n | ~power_up_reset_in_n;
	wire vrst_release = vme_system_reset_in_n & ~srst_d_reg;
	wire both_rst = ~power_up_reset_in_n & ~local_bus_reset_in_n;
	wire cfg_capture = lrst_rise & cfg_open_reg;

	// mode table; control lines other than stop/trdy must idle high
	wire ctl_idle = frame_n & irdy_n & devsel_n;
	bpsc_pkg::bpsc_mode_t mode_dec;
	assign mode_dec = !ctl_idle ? bpsc_pkg::MODE_INVALID :
		(stop_n && trdy_n) ?
			(m66en ? bpsc_pkg::MODE_PCI66 : bpsc_pkg::MODE_PCI33) :
		(stop_n && !trdy_n) ? bpsc_pkg::MODE_PCIX66 :
		(!stop_n && trdy_n) ? bpsc_pkg::MODE_PCIX100 :
		bpsc_pkg::MODE_PCIX133;
	bpsc_pkg::bpsc_pci_cfg_t pci_cfg_next;
	assign pci_cfg_next = '{width32: req64_n, mode: mode_dec};

	// slot decode; ga pins are active low, so all high means no slot
	wire ga_all_high = &ga_n;
	bpsc_pkg::bpsc_slot_t slot_mode;
	assign slot_mode =
		(!strap_reg.auto_slot_id_enable &&
			!strap_reg.geographic_slot_id_enable) ? bpsc_pkg::SLOT_OFF :
		!strap_reg.auto_slot_id_enable ? bpsc_pkg::SLOT_GEO :
		!strap_reg.geographic_slot_id_enable ? bpsc_pkg::SLOT_AUTO :
		ga_all_high ? bpsc_pkg::SLOT_AUTO : bpsc_pkg::SLOT_GEO;
	wire auto_sel = (slot_mode == bpsc_pkg::SLOT_AUTO);
	wire csr_en_rv = (slot_mode == bpsc_pkg::SLOT_GEO);
	wire [bpsc_pkg::GA_W-1:0] base_rv =
		strap_reg.geographic_slot_id_enable ? ~ga_n : '0;

	// apb decode
	wire setup = psel & ~penable;
	wire wr = psel & penable & pwrite;
	wire hit_stat = (paddr == bpsc_pkg::OFS_STRAP_STATUS);
	wire hit_ctrl = (paddr == bpsc_pkg::OFS_VME_CONTROL);
	wire hit_csr = (paddr == bpsc_pkg::OFS_SYS_CSR);
	wire hit_bset = (paddr == bpsc_pkg::OFS_BIT_SET);
	wire hit_bclr = (paddr == bpsc_pkg::OFS_BIT_CLR);
	wire hit_base = (paddr == bpsc_pkg::OFS_CSR_BASE);
	wire mapped = hit_stat | hit_ctrl | hit_csr | hit_bset | hit_bclr | hit_base;
	wire wr_ctrl = wr & hit_ctrl;
	wire wr_csr = wr & hit_csr;
	wire wr_base = wr & hit_base;
	wire sf_set = wr & hit_bset & pwdata[bpsc_pkg::BIT_SFEN];
	wire sf_clr = wr & hit_bclr & pwdata[bpsc_pkg::BIT_SFEN];
	wire board_fail = board_fail_bit_reg | ~board_fail_input_n;
	wire tmr_expire = (tmr_reg == TMR_ONE);

	logic [31:0] rd_word;
	always_comb begin
		rd_word = '0;
		if (hit_stat) begin
			rd_word[bpsc_pkg::BIT_WIDTH32] = pci_cfg_reg.width32;
			rd_word[bpsc_pkg::BIT_MODE_LO +: 3] = pci_cfg_reg.mode;
			rd_word[bpsc_pkg::BIT_STRAP_LO +: 4] = strap_reg;
			rd_word[bpsc_pkg::BIT_SLOT_LO +: 2] = slot_mode;
			rd_word[bpsc_pkg::BIT_OPEN] = cfg_open_reg;
		end else if (hit_ctrl) begin
			rd_word[bpsc_pkg::BIT_HOLD] = hold_reg;
			rd_word[bpsc_pkg::BIT_IRQ2] = irq2_reg;
		end else if (hit_csr) begin
			rd_word[bpsc_pkg::BIT_SFEN] = sfen_reg;
			rd_word[bpsc_pkg::BIT_BOARD_FAIL] = board_fail_bit_reg;
			rd_word[bpsc_pkg::BIT_SFOUT] = sysfail_output;
			rd_word[bpsc_pkg::BIT_BOARD_IN] = ~board_fail_input_n;
		end else if (hit_bset || hit_bclr) begin
			rd_word[bpsc_pkg::BIT_SFEN] = sfen_reg;
		end else if (hit_base) begin
			rd_word[bpsc_pkg::BIT_CSR_EN] = csr_en_reg;
			rd_word[bpsc_pkg::BIT_BASE_HI:bpsc_pkg::BIT_BASE_LO] = base_reg;
		end
	end

	// reset level history and pci capture window
	always_ff @(posedge clk) begin
		if (srst) begin
			lrst_d_reg <= 1'b0;
			purst_d_reg <= 1'b0;
			srst_d_reg <= 1'b0;
			cfg_open_reg <= 1'b1;
			pci_cfg_reg <= '{width32: 1'b0, mode: bpsc_pkg::MODE_PCI33};
		end else if (clk_en) begin
			lrst_d_reg <= local_bus_reset_in_n;
			purst_d_reg <= power_up_reset_in_n;
			srst_d_reg <= vme_system_reset_in_n;
			if (both_rst)
				cfg_open_reg <= 1'b1;
			else if (cfg_capture)
				cfg_open_reg <= 1'b0;
			if (cfg_capture)
				pci_cfg_reg <= pci_cfg_next;
		end
	end

	// vme straps, caught only at power-up reset release
	always_ff @(posedge clk) begin
		if (srst)
			strap_reg <= '0;
		else if (clk_en && purst_rise)
			strap_reg <= vme_data_strap_bits;
	end

	// csr base: reset value reloads while vme reset is asserted
	always_ff @(posedge clk) begin
		if (srst) begin
			csr_en_reg <= 1'b0;
			base_reg <= '0;
		end else if (clk_en) begin
			if (vrst_active) begin
				csr_en_reg <= csr_en_rv;
				base_reg <= base_rv;
			end else if (wr_base) begin
				csr_en_reg <= pwdata[bpsc_pkg::BIT_CSR_EN];
				base_reg <= pwdata[bpsc_pkg::BIT_BASE_HI:bpsc_pkg::BIT_BASE_LO];
			end
		end
	end

	// hold bit: reset load wins over software, timer clears it
	always_ff @(posedge clk) begin
		if (srst) begin
			hold_reg <= 1'b0;
			tmr_reg <= '0;
		end else if (clk_en) begin
			if (vrst_active) begin
				hold_reg <= auto_sel;
				tmr_reg <= '0;
			end else if (vrst_release && auto_sel &&
					strap_reg.autoslot_hold_autoclear) begin
				tmr_reg <= TMR_LOAD;
				if (wr_ctrl)
					hold_reg <= pwdata[bpsc_pkg::BIT_HOLD];
			end else begin
				if (tmr_reg != '0)
					tmr_reg <= tmr_reg - TMR_ONE;
				if (wr_ctrl)
					hold_reg <= pwdata[bpsc_pkg::BIT_HOLD];
				else if (tmr_expire)
					hold_reg <= 1'b0;
			end
		end
	end

	// sysfail enable and board fail bit
	always_ff @(posedge clk) begin
		if (srst) begin
			sfen_reg <= 1'b0;
			board_fail_bit_reg <= 1'b0;
		end else if (clk_en) begin
			if (vrst_active)
				sfen_reg <= strap_reg.sysfail_enable_reset_value;
			else if (sf_set)
				sfen_reg <= 1'b1;
			else if (sf_clr)
				sfen_reg <= 1'b0;
			else if (wr_csr)
				sfen_reg <= pwdata[bpsc_pkg::BIT_SFEN];
			if (wr_csr)
				board_fail_bit_reg <= pwdata[bpsc_pkg::BIT_BOARD_FAIL];
		end
	end

	// irq2 request until the monarch programs the base register
	always_ff @(posedge clk) begin
		if (srst)
			irq2_reg <= 1'b0;
		else if (clk_en) begin
			if (vrst_active)
				irq2_reg <= 1'b0;
			else if (vrst_release && auto_sel)
				irq2_reg <= 1'b1;
			else if (wr_base)
				irq2_reg <= 1'b0;
		end
	end

	// read data sampled in the setup cycle, stable through access
	always_ff @(posedge clk) begin
		if (srst)
			prdata_reg <= '0;
		else if (clk_en && setup)
			prdata_reg <= rd_word;
	end

	assign prdata = prdata_reg;
	// zero wait states; frozen clock means no transfer can complete
	assign pready = clk_en;
	assign pslverr = psel & penable & ~mapped;
	assign transceiver_output_enable_n = ~power_up_reset_in_n;
	assign upper_lane_drive_en = pci_cfg_reg.width32;
	assign pci_cfg = pci_cfg_reg;
	assign csr_enable = csr_en_reg;
	assign csr_base_bits = base_reg;
	assign irq2_request = irq2_reg;
	// hold forces sysfail so the monarch waits for slot assignment
	assign sysfail_output = hold_reg | (sfen_reg & board_fail);

	a_width_capture: assert property (@(posedge clk) disable iff (srst)
		clk_en && cfg_capture |=> pci_cfg.width32 == $past(req64_n))
		else $error("bus width not captured from req64_n");
	a_mode_capture: assert property (@(posedge clk) disable iff (srst)
		clk_en && cfg_capture |=> pci_cfg.mode == $past(mode_dec))
		else $error("bus mode not captured at local reset release");
	a_mode_once: assert property (@(posedge clk) disable iff (srst)
		!cfg_open_reg && !both_rst |=> $stable(pci_cfg))
		else $error("pci config changed while latch closed");
	a_xcvr_off: assert property (@(posedge clk) disable iff (srst)
		!power_up_reset_in_n |-> transceiver_output_enable_n)
		else $error("transceiver enabled during power-up reset");
	a_strap_latch: assert property (@(posedge clk) disable iff (srst)
		clk_en && purst_rise |=> strap_reg == $past(vme_data_strap_bits)
			##1 (!clk_en || purst_rise || $stable(strap_reg)))
		else $error("strap options not latched or not held");
	a_geo_load: assert property (@(posedge clk) disable iff (srst)
		clk_en && vrst_active && strap_reg.geographic_slot_id_enable
			&& !ga_all_high |=> csr_enable && csr_base_bits == ~$past(ga_n))
		else $error("geographic base not loaded from ga");
	a_hold_load: assert property (@(posedge clk) disable iff (srst)
		clk_en && vrst_active |=> hold_reg == $past(auto_sel)
			&& sfen_reg == $past(strap_reg.sysfail_enable_reset_value))
		else $error("reset values not loaded on vme reset");
	a_autoclr: assert property (@(posedge clk) disable iff (srst)
		clk_en && tmr_expire && !vrst_active && !wr_ctrl |=> !hold_reg)
		else $error("hold bit not auto cleared on timer expiry");
	a_hold_sysfail: assert property (@(posedge clk) disable iff (srst)
		hold_reg |-> sysfail_output)
		else $error("sysfail output negated while hold set");
	a_bit_clear: assert property (@(posedge clk) disable iff (srst)
		clk_en && sf_clr && !sf_set && !vrst_active |=> !sfen_reg
			##0 (hold_reg || !sysfail_output))
		else $error("bit clear did not disable sysfail");
	a_upper_drive: assert property (@(posedge clk) disable iff (srst)
		pci_cfg.width32 |-> upper_lane_drive_en)
		else $error("upper lanes not driven in 32-bit mode");
endmodule : bpsc_strap_loader

// ---- tb/bpsc_board_model.sv ----
// board model: vme data-line pull resistors behind the transceivers.
// assumes pins stay valid two clocks after the transceivers turn on.
module bpsc_board_model (
	input wire logic clk,
	input wire logic transceiver_output_enable_n,
	input wire logic [3:0] pull_bits,
	output logic [3:0] vme_data_strap_bits
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] on_cnt = 2'h0;
	logic [3:0] bus_q = 4'h5;
	logic [3:0] legal;
	// sysfail value never strapped high together with auto slot
	assign legal = {pull_bits[3:1], pull_bits[0] & ~pull_bits[2]};
	always @(posedge clk) begin
		bus_q <= ~bus_q;
		if (transceiver_output_enable_n) begin
			on_cnt <= 2'h0;
		end else if (on_cnt != 2'h2) begin
			on_cnt <= on_cnt + 2'h1;
		end
	end
	// after the hold the lines carry traffic, not the pulls
	assign vme_data_strap_bits = (on_cnt != 2'h2) ? legal : bus_q;
endmodule : bpsc_board_model

// ---- tb/tb.sv ----
// testbench: strap loader, board model, apb master.
// assumes a 200 MHz clk and the designer's register map.
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [3:0] p; logic [4:0] g; logic en; logic [4:0] b;
		logic hold; logic sf; logic [1:0] slot; logic ac;} bpsc_vrow_t;
	typedef struct {logic m66; logic stp; logic trd; logic dev; logic r64;
		bpsc_pkg::bpsc_mode_t mode;} bpsc_prow_t;
	localparam int AC = 20;
	logic clk = 0, srst = 1, clk_en = 1, lr_n = 0, pu_n = 0, vs_n = 0;
	logic req64_n = 1, m66en = 0, frame_n = 1, irdy_n = 1, trdy_n = 1;
	logic stop_n = 1, devsel_n = 1, bf_n = 1, psel = 0, penable = 0;
	logic pwrite = 0, pready, pslverr, toe_n, ulde, csr_enable, irq2_request;
	logic sysfail_output, err;
	logic [3:0] pull = 0, straps;
	logic [4:0] ga_n = 5'h1f, csr_base_bits;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, sv;
	bpsc_pkg::bpsc_pci_cfg_t pci_cfg;
	int bad_count = 0, n_checks = 0, n;
	bpsc_vrow_t vr[9] = '{'{4'h0, 5'h0a, 0, 0, 0, 0, 0, 0},
		'{4'h3, 5'h0a, 0, 0, 0, 1, 0, 0}, '{4'h4, 5'h0a, 0, 0, 1, 0, 2, 0},
		'{4'h6, 5'h0a, 0, 0, 1, 0, 2, 1}, '{4'h8, 5'h0a, 1, 5'h15, 0, 0, 1, 0},
		'{4'h9, 5'h0a, 1, 5'h15, 0, 1, 1, 0}, '{4'hc, 5'h05, 1, 5'h1a, 0, 0, 1, 0},
		'{4'hc, 5'h1f, 0, 0, 1, 0, 2, 0}, '{4'he, 5'h1f, 0, 0, 1, 0, 2, 1}};
	bpsc_prow_t pr[6] = '{'{0, 1, 1, 0, 0, bpsc_pkg::MODE_INVALID},
		'{0, 1, 1, 1, 1, bpsc_pkg::MODE_PCI33},
		'{1, 1, 1, 1, 0, bpsc_pkg::MODE_PCI66},
		'{0, 1, 0, 1, 1, bpsc_pkg::MODE_PCIX66},
		'{1, 0, 1, 1, 0, bpsc_pkg::MODE_PCIX100},
		'{0, 0, 0, 1, 1, bpsc_pkg::MODE_PCIX133}};
	bpsc_strap_loader #(.AUTOCLR_CYCLES(AC)) dut_u (.clk, .srst, .clk_en,
		.local_bus_reset_in_n(lr_n), .power_up_reset_in_n(pu_n),
		.vme_system_reset_in_n(vs_n), .req64_n, .m66en, .frame_n, .irdy_n,
		.trdy_n, .stop_n, .devsel_n, .vme_data_strap_bits(straps), .ga_n,
		.board_fail_input_n(bf_n), .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .transceiver_output_enable_n(toe_n),
		.upper_lane_drive_en(ulde), .pci_cfg, .csr_enable, .csr_base_bits,
		.irq2_request, .sysfail_output);
	bpsc_board_model brd_u (.clk, .transceiver_output_enable_n(toe_n),
		.pull_bits(pull), .vme_data_strap_bits(straps));
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : cyc
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) begin
			bad_count++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	// power-up reset with vme reset, straps from the board pulls
	task automatic boot(input logic [3:0] p, input logic [4:0] g);
		@(posedge clk);
		pull <= p;
		ga_n <= g;
		pu_n <= 0;
		vs_n <= 0;
		cyc(3);
		chk(toe_n, 1);
		@(posedge clk);
		pu_n <= 1;
		cyc(3);
		@(posedge clk);
		vs_n <= 1;
	endtask : boot
	initial begin
		repeat (50000) @(posedge clk);
		bad_count++;
		give_verdict();
	end
	initial begin
		repeat (10) @(posedge clk);
		srst <= 0;
		cyc(1);
		chk({pci_cfg, csr_enable, csr_base_bits, irq2_request, sysfail_output}, 0);
		foreach (pr[i]) begin
			@(posedge clk);
			{m66en, stop_n, trdy_n, devsel_n} <= {pr[i].m66, pr[i].stp, pr[i].trd,
				pr[i].dev};
			req64_n <= pr[i].r64; // each row is its own bus
			lr_n <= 0;
			pu_n <= 0;
			cyc(2);
			@(posedge clk);
			pu_n <= 1;
			@(posedge clk);
			lr_n <= 1;
			cyc(3);
			chk(pci_cfg, {pr[i].r64, pr[i].mode});
			chk(ulde, pr[i].r64);
		end
		// local reset alone must not recapture
		@(posedge clk);
		req64_n <= 0;
		stop_n <= 1;
		trdy_n <= 1;
		lr_n <= 0;
		cyc(2);
		@(posedge clk);
		lr_n <= 1;
		cyc(3);
		chk(pci_cfg, {1'b1, bpsc_pkg::MODE_PCIX133});
		apb(bpsc_pkg::OFS_STRAP_STATUS, 0, 0);
		chk({rd[10], rd[3:0]}, {1'b0, bpsc_pkg::MODE_PCIX133, 1'b1});
		foreach (vr[i]) begin
			boot(vr[i].p, vr[i].g);
			for (n = 1; n <= 40; n++) begin
				cyc(1);
				if (sysfail_output !== 1'b1) break;
			end
			chk(n, vr[i].ac ? AC + 1 : (vr[i].hold ? 41 : 1));
			chk({csr_enable, csr_base_bits, irq2_request},
				{vr[i].en, vr[i].b, vr[i].slot == 2});
			apb(bpsc_pkg::OFS_VME_CONTROL, 0, 0);
			chk(rd[0], vr[i].hold & ~vr[i].ac);
			apb(bpsc_pkg::OFS_SYS_CSR, 0, 0);
			chk(rd[0], vr[i].sf);
			apb(bpsc_pkg::OFS_STRAP_STATUS, 0, 0);
			chk(rd[9:4], {vr[i].slot, vr[i].p});
			if (vr[i].hold && !vr[i].ac) begin
				apb(bpsc_pkg::OFS_VME_CONTROL, 1, 0);
				cyc(1);
				chk(sysfail_output, 0);
			end
		end
		boot(4'h8, 5'h0a);
		apb(bpsc_pkg::OFS_CSR_BASE, 1, 0);
		@(posedge clk);
		vs_n <= 0;
		cyc(2);
		@(posedge clk);
		vs_n <= 1;
		cyc(2);
		chk({csr_enable, csr_base_bits}, 6'h35);
		boot(4'h4, 5'h0a);
		cyc(2);
		// monarch waits for sysfail to drop; enable only after auto slot
		apb(bpsc_pkg::OFS_VME_CONTROL, 1, 0);
		cyc(1);
		chk(sysfail_output, 0);
		apb(bpsc_pkg::OFS_CSR_BASE, 1, 32'h19);
		cyc(1);
		chk({irq2_request, csr_enable, csr_base_bits}, 7'h23);
		apb(bpsc_pkg::OFS_BIT_SET, 1, 1);
		@(posedge clk);
		bf_n <= 0;
		cyc(1);
		chk(sysfail_output, 1);
		apb(bpsc_pkg::OFS_BIT_CLR, 1, 1);
		cyc(1);
		chk(sysfail_output, 0);
		@(posedge clk);
		bf_n <= 1;
		apb(bpsc_pkg::OFS_SYS_CSR, 1, 3);
		cyc(1);
		chk(sysfail_output, 1);
		apb(bpsc_pkg::OFS_SYS_CSR, 1, 0);
		cyc(1);
		chk(sysfail_output, 0);
		// frozen clock: vme reset must not reload, no transfer completes
		@(posedge clk);
		clk_en <= 0;
		vs_n <= 0;
		cyc(3);
		chk({pready, csr_enable, csr_base_bits}, 7'h23);
		@(posedge clk);
		clk_en <= 1;
		cyc(1);
		chk({csr_enable, csr_base_bits}, 0);
		@(posedge clk);
		vs_n <= 1;
		apb(8'h40, 0, 0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		apb(bpsc_pkg::OFS_STRAP_STATUS, 0, 0);
		sv = rd;
		apb(bpsc_pkg::OFS_STRAP_STATUS, 1, 32'hffffffff);
		apb(bpsc_pkg::OFS_STRAP_STATUS, 0, 0);
		chk(rd, sv);
		give_verdict();
	end
endmodule : tb
